/* dwc_pkg.sv */
// Package with constants and types for the waveform control block
package dwc_pkg;
    localparam int WORD_W     = 16;
    localparam int ACC_W      = 28;
    localparam int HALF_W     = 14;
    localparam int PH_W       = 12;
    localparam int DAC_W      = 10;
    localparam int LUT_W      = 8;
    // Write word address field
    localparam logic [1:0] ADDR_CTRL  = 2'h0;
    localparam logic [1:0] ADDR_FREQA = 2'h1;
    localparam logic [1:0] ADDR_FREQB = 2'h2;
    localparam logic [1:0] ADDR_PHASE = 2'h3;
    // Field positions inside a write word
    localparam int ADDR_HI    = 15;
    localparam int ADDR_LO    = 14;
    localparam int PH_SEL_BIT = 13;
    // Control word bit positions
    localparam int CB_FULL    = 13;
    localparam int CB_HALF    = 12;
    localparam int CB_FREQUENCY_SELECT    = 11;
    localparam int CB_PSEL    = 10;
    localparam int CB_RESET   = 8;
    localparam int CB_CSLEEP  = 7;
    localparam int CB_DSLEEP  = 6;
    localparam int CB_OPBIT   = 5;
    localparam int CB_DIV     = 3;
    localparam int CB_MODE    = 1;
    // Latency from reset release to output, master clock cycles
    localparam int START_LAT  = 7;
    localparam logic [DAC_W-1:0] DAC_MID = 10'h200;

    typedef struct packed {
        logic full_width_write;
        logic half_select;
        logic frequency_select;
        logic phase_select;
        logic gen_reset;
        logic clock_sleep;
        logic dac_sleep;
        logic output_bit_enable;
        logic square_divide_select;
        logic wave_mode;
    } dwc_ctrl_t;

    localparam dwc_ctrl_t CTRL_RST = '{default: 1'b0, gen_reset: 1'b1};
endpackage

/* dwc_serial_master.sv */
// Serial master model that frames 16-bit write words
module dwc_serial_master (
    input  wire logic mclk,
    output logic      serial_clk,
    output logic      serial_in,
    output logic      frame_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        serial_clk = 1'b1;
        serial_in = 1'b0;
        frame_strobe_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Clock idles high; a bit is set while high and taken at the fall
    task automatic send_word(input logic [15:0] w, input int half);
        frame_strobe_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in = w[i];
            tick(half);
            serial_clk = 1'b0;
            tick(half);
            serial_clk = 1'b1;
        end
        serial_in = ~w[0];
        tick(half);
        frame_strobe_n = 1'b1;
        tick(45);
    endtask
endmodule // dwc_serial_master

/* dwc_sine_lut.sv */
// Quarter-wave sine amplitude lookup, full cycle folded
module dwc_sine_lut (
    input  wire logic [9:0] phase,
    output logic      [9:0] amp
);
    logic [7:0] idx;
    logic [8:0] mag;

    assign idx = phase[8] ? ~phase[7:0] : phase[7:0];

    always_comb begin
        mag = 9'h0;
        for (int i = 0; i < 256; i++) begin
            if (idx == 8'(i)) begin
                mag = 9'($rtoi(511.0 * $sin(3.14159265358979 * (i + 0.5) / 512.0)));
            end
        end
    end

    assign amp = phase[9] ? 10'(10'h200 - {1'b0, mag}) : 10'(10'h200 + {1'b0, mag});
endmodule // dwc_sine_lut

/* dwc_sync.sv */
// Three-stage synchroniser with agreement filter
module dwc_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            q    <= 1'b1;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q <= s3_q;
            end
        end
    end
endmodule // dwc_sync

/* dwc_waveform_control.sv */
// Serial-programmed direct digital synthesis control and output path
// Function
// - Top bits 01/10 load frequency word A/B
// - Full-width mode: low half then high half
// - Half mode, select 0: low half only
// - Half mode, select 1: high half only
// - Top bits 11 mean phase load
// - Bit 13 picks phase A/B, 12-bit value
// - Frequency steps accumulator, phase adds to its output
// - Reset bit clears accumulator to zero, output to midscale
// - Reset keeps frequency, phase, control registers
// - Output starts seven cycles after reset release
// - DAC sleep kills DAC, accumulator runs
// - Clock sleep freezes accumulator and output
// - Serial writes accepted during clock sleep
// - Select bits honoured during clock sleep
// - Waking resumes output at once, without the start latency
// - Sine output through lookup
// - Triangle output bypasses lookup
// - Triangle is 10-bit linear code
// - Square MSB or MSB halved
module dwc_waveform_control #(
    parameter int ACC_W = dwc_pkg::ACC_W
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       serial_clk,
    input  wire logic                       serial_in,
    input  wire logic                       frame_strobe_n,
    output logic      [dwc_pkg::DAC_W-1:0]  dac_code,
    output logic                            dac_enable,
    output logic                            wave_out_pin
);
    localparam int PH_W  = dwc_pkg::PH_W;
    localparam int DAC_W = dwc_pkg::DAC_W;
    localparam int HW    = dwc_pkg::HALF_W;

    // Pin synchronisers; serial clock sampled as an ordinary input
    logic sclk_s;
    logic sdi_s;
    logic fs_s;

    dwc_sync u_sync_clk (.mclk(mclk), .rst_n(rst_n), .d(serial_clk),     .q(sclk_s));
    dwc_sync u_sync_dat (.mclk(mclk), .rst_n(rst_n), .d(serial_in),      .q(sdi_s));
    dwc_sync u_sync_fs  (.mclk(mclk), .rst_n(rst_n), .d(frame_strobe_n), .q(fs_s));

    // Serial shifter: data taken on falling serial clock, MSB first
    logic        sclk_prev_q;
    logic [15:0] shift_q;
    logic [4:0]  bit_cnt_q;
    logic        word_vld_q;
    logic [15:0] word_q;
    wire         sclk_fall = sclk_prev_q & ~sclk_s;
    wire         bit_take  = sclk_fall & ~fs_s;
    wire         last_bit  = bit_take & (bit_cnt_q == 5'(dwc_pkg::WORD_W - 1));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b1;
            shift_q     <= 16'h0;
            bit_cnt_q   <= 5'h0;
            word_vld_q  <= 1'b0;
            word_q      <= 16'h0;
        end else begin
            sclk_prev_q <= sclk_s;
            word_vld_q  <= last_bit;
            if (fs_s) begin
                bit_cnt_q <= 5'h0;
            end else if (bit_take) begin
                shift_q   <= {shift_q[14:0], sdi_s};
                bit_cnt_q <= last_bit ? 5'h0 : 5'(bit_cnt_q + 5'h1);
                if (last_bit) begin
                    word_q <= {shift_q[14:0], sdi_s};
                end
            end
        end
    end

    // Word decode
    wire [1:0]    w_addr   = word_q[dwc_pkg::ADDR_HI:dwc_pkg::ADDR_LO];
    wire [HW-1:0] w_pay    = word_q[HW-1:0];
    wire          is_ctrl  = word_vld_q & (w_addr == dwc_pkg::ADDR_CTRL);
    wire          is_fa    = word_vld_q & (w_addr == dwc_pkg::ADDR_FREQA);
    wire          is_fb    = word_vld_q & (w_addr == dwc_pkg::ADDR_FREQB);
    wire          is_ph    = word_vld_q & (w_addr == dwc_pkg::ADDR_PHASE);
    wire          ph_b     = word_q[dwc_pkg::PH_SEL_BIT];

    dwc_pkg::dwc_ctrl_t ctrl_q;
    logic [ACC_W-1:0]   freq_a_q;
    logic [ACC_W-1:0]   freq_b_q;
    logic [PH_W-1:0]    phase_a_q;
    logic [PH_W-1:0]    phase_b_q;
    logic               hi_next_a_q;
    logic               hi_next_b_q;

    // Which half of a frequency word the current write goes to
    wire wr_hi_a = ctrl_q.full_width_write ? hi_next_a_q : ctrl_q.half_select;
    wire wr_hi_b = ctrl_q.full_width_write ? hi_next_b_q : ctrl_q.half_select;

    // Register writes run regardless of sleep or reset bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q      <= dwc_pkg::CTRL_RST;
            freq_a_q    <= '0;
            freq_b_q    <= '0;
            phase_a_q   <= '0;
            phase_b_q   <= '0;
            hi_next_a_q <= 1'b0;
            hi_next_b_q <= 1'b0;
        end else begin
            if (is_ctrl) begin
                ctrl_q.full_width_write     <= word_q[dwc_pkg::CB_FULL];
                ctrl_q.half_select          <= word_q[dwc_pkg::CB_HALF];
                ctrl_q.frequency_select     <= word_q[dwc_pkg::CB_FREQUENCY_SELECT];
                ctrl_q.phase_select         <= word_q[dwc_pkg::CB_PSEL];
                ctrl_q.gen_reset            <= word_q[dwc_pkg::CB_RESET];
                ctrl_q.clock_sleep          <= word_q[dwc_pkg::CB_CSLEEP];
                ctrl_q.dac_sleep            <= word_q[dwc_pkg::CB_DSLEEP];
                ctrl_q.output_bit_enable    <= word_q[dwc_pkg::CB_OPBIT];
                ctrl_q.square_divide_select <= word_q[dwc_pkg::CB_DIV];
                ctrl_q.wave_mode            <= word_q[dwc_pkg::CB_MODE];
                hi_next_a_q                 <= 1'b0;
                hi_next_b_q                 <= 1'b0;
            end
            if (is_fa) begin
                if (wr_hi_a) begin
                    freq_a_q[ACC_W-1:HW] <= w_pay;
                end else begin
                    freq_a_q[HW-1:0] <= w_pay;
                end
                hi_next_a_q <= ctrl_q.full_width_write & ~hi_next_a_q;
            end
            if (is_fb) begin
                if (wr_hi_b) begin
                    freq_b_q[ACC_W-1:HW] <= w_pay;
                end else begin
                    freq_b_q[HW-1:0] <= w_pay;
                end
                hi_next_b_q <= ctrl_q.full_width_write & ~hi_next_b_q;
            end
            if (is_ph & ~ph_b) begin
                phase_a_q <= word_q[PH_W-1:0];
            end
            if (is_ph & ph_b) begin
                phase_b_q <= word_q[PH_W-1:0];
            end
        end
    end

    // Generation pipeline: accumulator, phase add, shaping, output
    wire [ACC_W-1:0] freq_sel  = ctrl_q.frequency_select ? freq_b_q : freq_a_q;
    wire [PH_W-1:0]  phase_sel = ctrl_q.phase_select ? phase_b_q : phase_a_q;
    wire             run       = ~ctrl_q.clock_sleep;

    logic [ACC_W-1:0] acc_q;
    logic [PH_W-1:0]  ph_q;
    logic [DAC_W-1:0] tri_q;
    logic [DAC_W-1:0] sin_q;
    logic [DAC_W-1:0] shaped_q;
    logic             msb_q;
    logic             msb_prev_q;
    logic             half_q;
    logic [2:0]       lat_q;
    logic [DAC_W-1:0] sine_amp;

    wire [PH_W-1:0] ph_sum = PH_W'(acc_q[ACC_W-1 -: PH_W] + phase_sel);
    // Fold the top phase bit so the code ramps up then down
    wire [DAC_W-1:0] tri_code = ph_q[PH_W-1] ? ~ph_q[PH_W-2 -: DAC_W]
                                             : ph_q[PH_W-2 -: DAC_W];

    dwc_sine_lut u_sine (.phase(ph_q[PH_W-1 -: DAC_W]), .amp(sine_amp));

    always_ff @(posedge mclk) begin
        if (!rst_n || ctrl_q.gen_reset) begin
            acc_q      <= '0;
            ph_q       <= '0;
            tri_q      <= '0;
            sin_q      <= dwc_pkg::DAC_MID;
            shaped_q   <= dwc_pkg::DAC_MID;
            msb_q      <= 1'b0;
            msb_prev_q <= 1'b0;
            half_q     <= 1'b0;
            lat_q      <= 3'h0;
        end else if (run) begin
            acc_q      <= ACC_W'(acc_q + freq_sel);
            ph_q       <= ph_sum;
            tri_q      <= tri_code;
            sin_q      <= sine_amp;
            shaped_q   <= ctrl_q.wave_mode ? tri_q : sin_q;
            msb_q      <= shaped_q[DAC_W-1];
            msb_prev_q <= msb_q;
            if (msb_q & ~msb_prev_q) begin
                half_q <= ~half_q;
            end
            if (lat_q != 3'(dwc_pkg::START_LAT - 1)) begin
                lat_q <= 3'(lat_q + 3'h1);
            end
        end
    end

    wire started = (lat_q == 3'(dwc_pkg::START_LAT - 1));

    // Output register: code and pin held in clock sleep (enable still follows DAC sleep), midscale until latency elapsed
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dac_code     <= dwc_pkg::DAC_MID;
            dac_enable   <= 1'b0;
            wave_out_pin <= 1'b0;
        end else begin
            dac_enable <= ~ctrl_q.dac_sleep;
            if (ctrl_q.gen_reset) begin
                dac_code     <= dwc_pkg::DAC_MID;
                wave_out_pin <= 1'b0;
            end else if (run) begin
                dac_code <= started ? shaped_q : dwc_pkg::DAC_MID;
                if (ctrl_q.output_bit_enable) begin
                    wave_out_pin <= started &
                        (ctrl_q.square_divide_select ? msb_q : half_q);
                end else begin
                    wave_out_pin <= started & shaped_q[DAC_W-1];
                end
            end
        end
    end
endmodule // dwc_waveform_control

/* dwc_waveform_control_assertions.sv */
// Port checker for the waveform control block
module dwc_waveform_control_checker #(
    parameter int ACC_W = dwc_pkg::ACC_W
) (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire logic                      serial_clk,
    input wire logic                      serial_in,
    input wire logic                      frame_strobe_n,
    input wire logic [dwc_pkg::DAC_W-1:0] dac_code,
    input wire logic                      dac_enable,
    input wire logic                      wave_out_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] idle_q;
    logic [5:0] idle_d;
    // Cycles with the strobe high, saturating at 40
    assign idle_d = !frame_strobe_n ? 6'h00 : (idle_q == 6'h28) ? idle_q : idle_q + 6'h01;
    always_ff @(posedge mclk) begin
        idle_q <= rst_n ? idle_d : 6'h00;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_reset_mid;
        $rose(rst_n) |-> dac_code == dwc_pkg::DAC_MID && !dac_enable && !wave_out_pin;
    endproperty
    a_reset_mid: assert property (p_reset_mid) else $error("bad reset outputs");
    property p_enable_up;
        $rose(rst_n) |=> dac_enable [*8];
    endproperty
    a_enable_up: assert property (p_enable_up) else $error("dac not enabled");
    property p_mid_hold;
        $rose(rst_n) |=> (dac_code == dwc_pkg::DAC_MID) [*8];
    endproperty
    a_mid_hold: assert property (p_mid_hold) else $error("left midscale early");
    property p_pin_settle;
        $rose(rst_n) |=> ##2 $stable(wave_out_pin) [*6];
    endproperty
    a_pin_settle: assert property (p_pin_settle) else $error("pin moved in reset");
    property p_enable_spacing;
        $changed(dac_enable) |=> $stable(dac_enable) [*6];
    endproperty
    a_enable_spacing: assert property (p_enable_spacing) else $error("enable glitch");
    property p_idle_quiet;
        frame_strobe_n && idle_q == 6'h28 |=> $stable(dac_enable);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("change while idle");
    property p_frame_start;
        $fell(frame_strobe_n) && idle_q == 6'h28 |=> $stable(dac_enable) [*8];
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("early apply");
    property p_freeze_pair;
        dac_enable && $stable(dac_code) [*4] |-> $stable(wave_out_pin);
    endproperty
    a_freeze_pair: assert property (p_freeze_pair) else $error("pin moved frozen");
endmodule // dwc_waveform_control_checker

bind dwc_waveform_control dwc_waveform_control_checker #(.ACC_W(ACC_W)) u_checker (
    .mclk(mclk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .frame_strobe_n(frame_strobe_n), .dac_code(dac_code), .dac_enable(dac_enable),
    .wave_out_pin(wave_out_pin));

/* tb_top.sv */
// Self-checking testbench for the waveform control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, serial_clk, serial_in, frame_strobe_n, dac_enable, wave_out_pin;
    logic [dwc_pkg::DAC_W-1:0] dac_code, frozen;
    dwc_pkg::dwc_ctrl_t        ctl;
    int                        fails, checks, k, k2, n;
    dwc_serial_master master (.mclk(mclk), .serial_clk(serial_clk), .serial_in(serial_in),
        .frame_strobe_n(frame_strobe_n));
    dwc_waveform_control dut (.mclk(mclk), .rst_n(rst_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .frame_strobe_n(frame_strobe_n), .dac_code(dac_code),
        .dac_enable(dac_enable), .wave_out_pin(wave_out_pin));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [13:0] hi_half(input int kk);
        return 14'(kk << 3);
    endfunction
    function automatic int tri_start(input int p);
        return p >> 1;
    endfunction
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] got);
        checks++;
        if (^got === 1'bx || got < lo || got > hi) begin
            fails++;
            $display("wrong value %s expected %0d..%0d seen %h", nm, lo, hi, got);
        end
    endtask
    task automatic send(input logic [15:0] w);
        master.send_word(w, $urandom_range(5, 7));
    endtask
    task automatic send_ctl();
        logic [15:0] w;
        w = 16'h0000;
        w[dwc_pkg::CB_FULL] = ctl.full_width_write;
        w[dwc_pkg::CB_HALF] = ctl.half_select;
        w[dwc_pkg::CB_FREQUENCY_SELECT] = ctl.frequency_select;
        w[dwc_pkg::CB_PSEL] = ctl.phase_select;
        w[dwc_pkg::CB_RESET] = ctl.gen_reset;
        w[dwc_pkg::CB_CSLEEP] = ctl.clock_sleep;
        w[dwc_pkg::CB_DSLEEP] = ctl.dac_sleep;
        w[dwc_pkg::CB_OPBIT] = ctl.output_bit_enable;
        w[dwc_pkg::CB_DIV] = ctl.square_divide_select;
        w[dwc_pkg::CB_MODE] = ctl.wave_mode;
        send(w);
    endtask
    task automatic slope(input int exp);
        logic [9:0] a;
        n = 0;
        while ((dac_code < 10'h064 || dac_code > 10'h384) && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        a = dac_code;
        @(posedge mclk);
        #1;
        chk("slope", 16'(exp), (dac_code > a) ? dac_code - a : a - dac_code);
    endtask
    // Counts cycles from the last falling serial edge to the first new code
    task automatic release_gen(input int p);
        logic [9:0] c;
        n = 0;
        ctl.gen_reset = 1'b0;
        fork
            send_ctl();
            begin
                repeat (16) @(negedge serial_clk);
                while (dac_code === dwc_pkg::DAC_MID && n < 40) begin
                    @(posedge mclk);
                    #1;
                    n++;
                end
                c = dac_code;
            end
        join
        chk_rng("latency", 11, 16, n);
        chk_rng("start", tri_start(p), tri_start(p) + 16 * k, c);
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(60000 * 20);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(476));
        rst_n = 1'b0;
        ctl = dwc_pkg::CTRL_RST;
        k = $urandom_range(1, 6);
        k2 = k + $urandom_range(1, 3);
        repeat (6) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk("mid", 16'h0200, dac_code);
        chk("dac_en", 16'h0001, dac_enable);
        ctl.full_width_write = 1'b1;
        ctl.wave_mode = 1'b1;
        send_ctl();
        send({2'h1, 14'h0000});
        send({2'h1, hi_half(k)});
        ctl.full_width_write = 1'b0;
        ctl.half_select = 1'b1;
        send_ctl();
        send({2'h2, hi_half(k2)});
        ctl.half_select = 1'b0;
        send_ctl();
        send({2'h2, 14'h0000});
        send({2'h3, 2'h0, 12'h100});
        send({2'h3, 2'h2, 12'h300});
        chk("held", 16'h0200, dac_code);
        release_gen(12'h100);
        slope(k);
        ctl.frequency_select = 1'b1;
        send_ctl();
        slope(k2);
        $display("test load and select done");
        ctl.clock_sleep = 1'b1;
        send_ctl();
        frozen = dac_code;
        ctl.frequency_select = 1'b0;
        send_ctl();
        chk("frozen", frozen, dac_code);
        ctl.clock_sleep = 1'b0;
        send_ctl();
        slope(k);
        $display("test sleep done");
        ctl.gen_reset = 1'b1;
        send_ctl();
        chk("mid", 16'h0200, dac_code);
        ctl.phase_select = 1'b1;
        release_gen(12'h300);
        slope(k);
        $display("test reset done");
        ctl.output_bit_enable = 1'b1;
        ctl.wave_mode = 1'b0;
        ctl.dac_sleep = 1'b1;
        for (int d = 1; d >= 0; d--) begin
            ctl.square_divide_select = d[0];
            send_ctl();
            chk("dac_en", 16'h0000, dac_enable);
            n = 0;
            frozen[0] = wave_out_pin;
            repeat (4096) begin
                @(posedge mclk);
                #1;
                n += (wave_out_pin !== frozen[0]);
                frozen[0] = wave_out_pin;
            end
            chk_rng("toggles", (2 + 2 * d) * k - 1, (2 + 2 * d) * k + 1, n);
        end
        $display("test square done");
        ctl.output_bit_enable = 1'b0;
        ctl.dac_sleep = 1'b0;
        send_ctl();
        chk("dac_en", 16'h0001, dac_enable);
        // A sine dwells near its crest far longer than a triangle does
        n = 0;
        repeat (4096) begin
            @(posedge mclk);
            #1;
            n += (dac_code >= 10'h3c0);
        end
        chk_rng("sine_top", 550, 750, n);
        $display("test sine done");
        complete_run();
    end
endmodule // tb_top
